/* File: logic/tfcd_regs.svh */
// Constants for the transmit frame control decoder
//
// Notes on behaviour
// - MAC generates preamble and start delimiter itself for every frame with bytes after the control byte.
// - First byte at start of each frame is a control byte, not data.
// - Override bit 0 set: control byte decides huge, pad and CRC handling.
// - Override clear: control bits ignored, global frame configuration used.
// - Override with bit 3 set: whole frame sent regardless of maximum length.
// - Override with bit 3 clear: abort frame once maximum length is reached.
// - Override with bit 2 set: zero-pad short frames to 60 bytes.
// - Override with bit 2 clear: never add padding bytes.
// - Override with bit 1 set: compute and append CRC after last byte.
// - Override with bit 1 clear: no CRC appended, last four bytes checked.
// - Global pad code: 001 pads 60, x11 pads 64, 101 VLAN-aware, even none.
// - Global CRC bit set appends CRC; clear checks last four bytes, reports error.
// - Global oversize bit clear aborts long frames; set allows any size.
// - On finish or abort, write seven-byte status after the end pointer.
`ifndef TFCD_REGS_SVH
`define TFCD_REGS_SVH

// ----------------------------------------------------------------------
// Control byte fields
// ----------------------------------------------------------------------
`define TFCD_CB_OVERRIDE     0
`define TFCD_CB_CRC          1
`define TFCD_CB_PAD          2
`define TFCD_CB_HUGE         3

// ----------------------------------------------------------------------
// Frame constants
// ----------------------------------------------------------------------
`define TFCD_PREAMBLE_LEN    4'h7
`define TFCD_PREAMBLE_BYTE   8'h55
`define TFCD_SFD_BYTE        8'hd5
`define TFCD_MIN_SHORT       16'h003c
`define TFCD_MIN_LONG        16'h0040
`define TFCD_VLAN_TYPE       16'h8100
`define TFCD_TYPE_HI_POS     16'h000c
`define TFCD_TYPE_LO_POS     16'h000d
`define TFCD_CRC_INIT        32'hffffffff
`define TFCD_CRC_RESIDUE     32'hdebb20e3
`define TFCD_CRC_POLY        32'hedb88320
`define TFCD_STATUS_LEN      3'h7
`define TFCD_MAXLEN_RESET    16'h05ee

`endif

/* File: logic/tfcd_pkg.sv */
// Types for the transmit frame control decoder
package tfcd_pkg;

  // ----------------------------------------------------------------------
  // Transmit sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [8:0] {
    TFCD_IDLE   = 9'h001,
    TFCD_CTRL   = 9'h002,
    TFCD_PRE    = 9'h004,
    TFCD_DATA   = 9'h008,
    TFCD_PAD    = 9'h010,
    TFCD_FCS    = 9'h020,
    TFCD_STAT   = 9'h040,
    TFCD_FLUSH  = 9'h080,
    TFCD_DONE   = 9'h100
  } tfcd_state_e;

endpackage : tfcd_pkg

/* File: logic/tfcd_fifo.sv */
// Synchronous FIFO between buffer memory reader and the sequencer
`timescale 1ns/1ps
`default_nettype none
module tfcd_fifo
  import tfcd_pkg::*;
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
      $error("tfcd_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      wr_ptr <= '0;
    else if (push)
      wr_ptr <= wr_ptr + 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      rd_ptr <= '0;
    else if (pop)
      rd_ptr <= rd_ptr + 1'b1;
  end
endmodule : tfcd_fifo
`default_nettype wire

/* File: logic/tfcd_crc.sv */
// Byte-wide Ethernet CRC-32 accumulator
`timescale 1ns/1ps
`default_nettype none
module tfcd_crc
  import tfcd_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        clear,
  input  wire logic        enable,
  input  wire logic [7:0]  data,
  output logic      [31:0] crc,
  output logic             residue_ok
);
  `include "tfcd_regs.svh"

  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      if (r[0] ^ d[i])
        r = (r >> 1) ^ `TFCD_CRC_POLY;
      else
        r = r >> 1;
    end
    return r;
  endfunction : crc_step

  assign residue_ok = crc == `TFCD_CRC_RESIDUE;

  always_ff @(posedge sys_clk)
  begin
    if (rst || clear)
      crc <= `TFCD_CRC_INIT;
    else if (enable)
      crc <= crc_step(crc, data);
  end
endmodule : tfcd_crc
`default_nettype wire

/* File: logic/tfcd_top.sv */
// Transmit frame control decode and frame formation sequencer
`timescale 1ns/1ps
`default_nettype none
module tfcd_top
  import tfcd_pkg::*;
#(
  parameter int FIFO_DEPTH = 32,
  parameter int ADDR_W     = 13
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // Transmit request from the host side
  input  wire logic              tx_start,
  input  wire logic [ADDR_W-1:0] tx_start_pointer,
  input  wire logic [ADDR_W-1:0] tx_end_pointer,
  output logic                   tx_busy,
  output logic                   tx_done,
  output logic                   tx_abort,
  // Global frame configuration
  input  wire logic [2:0]        global_pad_crc_code,
  input  wire logic              global_crc_append,
  input  wire logic              global_oversize_allow,
  input  wire logic [15:0]       max_frame_length,
  // Buffer memory port
  output logic                   mem_rd_en,
  output logic      [ADDR_W-1:0] mem_addr,
  input  wire logic [7:0]        mem_rd_data,
  output logic                   mem_wr_en,
  output logic      [7:0]        mem_wr_data,
  // Byte stream to the line
  output logic      [7:0]        line_data,
  output logic                   line_valid,
  output logic                   line_sof,
  output logic                   line_eof,
  input  wire logic              line_ready,
  // Result of the last frame
  output logic                   crc_error,
  output logic                   giant
);
  `include "tfcd_regs.svh"

  initial
  begin
    if (FIFO_DEPTH < 2 || ADDR_W < 4 || ADDR_W > 16)
      $error("tfcd_top: unsupported parameter values");
  end

  // ----------------------------------------------------------------------
  // Memory reader feeding the FIFO
  // ----------------------------------------------------------------------
  tfcd_state_e       state;
  logic [ADDR_W-1:0] rd_ptr;
  logic [ADDR_W-1:0] wr_ptr;
  logic              rd_active;
  logic              rd_pending;
  logic              rd_last_q;
  logic [8:0]        fifo_in;
  logic              fifo_in_valid;
  logic              fifo_in_ready;
  logic [8:0]        fifo_out;
  logic              fifo_out_valid;
  logic              fifo_out_ready;
  logic              issue;

  // At most one read in flight, so FIFO space is never overrun
  assign issue     = rd_active && !rd_pending && fifo_in_ready && state != TFCD_STAT;
  assign mem_rd_en = issue;
  assign fifo_in   = {rd_last_q, mem_rd_data};
  assign fifo_in_valid = rd_pending;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rd_ptr     <= '0;
      rd_active  <= 1'b0;
      rd_pending <= 1'b0;
      rd_last_q  <= 1'b0;
    end
    else
    begin
      rd_pending <= issue;
      if (state == TFCD_IDLE && tx_start)
      begin
        rd_ptr    <= tx_start_pointer;
        rd_active <= 1'b1;
      end
      else if (issue)
      begin
        rd_last_q <= rd_ptr == tx_end_pointer;
        rd_ptr    <= rd_ptr + 1'b1;
        if (rd_ptr == tx_end_pointer)
          rd_active <= 1'b0;
      end
      // Reads go on through a flush so the last-byte mark reaches the FIFO
      else if (state == TFCD_DONE)
        rd_active <= 1'b0;
    end
  end

  tfcd_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_data   (fifo_in),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready)
  );

  // ----------------------------------------------------------------------
  // Control byte decode
  // ----------------------------------------------------------------------
  logic       ovr;
  logic       huge_en;
  logic [2:0] pad_mode;
  logic       crc_en;
  logic [7:0] ctrl;

  // Upper control bits are never looked at
  assign ovr = ctrl[`TFCD_CB_OVERRIDE];

  always_comb
  begin
    if (ovr)
    begin
      huge_en  = ctrl[`TFCD_CB_HUGE];
      pad_mode = ctrl[`TFCD_CB_PAD] ? 3'h1 : 3'h0;
      crc_en   = ctrl[`TFCD_CB_CRC];
    end
    else
    begin
      huge_en  = global_oversize_allow;
      pad_mode = global_pad_crc_code;
      crc_en   = global_crc_append;
    end
  end

  // ----------------------------------------------------------------------
  // Transmit sequencer
  // ----------------------------------------------------------------------
  logic [15:0] byte_cnt;
  logic [3:0]  sub_cnt;
  logic [15:0] type_field;
  logic [15:0] pad_target;
  logic        line_fire;
  logic        data_last;
  logic        over_limit;
  logic        crc_clear;
  logic        crc_en_step;
  logic [7:0]  crc_byte;
  logic [31:0] crc_val;
  logic        crc_ok;

  assign line_fire  = line_valid && line_ready;
  assign data_last  = fifo_out[8];
  assign over_limit = !huge_en && byte_cnt >= max_frame_length;

  always_comb
  begin
    if (pad_mode[0] == 1'b0)
      pad_target = '0;
    else if (pad_mode == 3'h5)
      pad_target = type_field == `TFCD_VLAN_TYPE ? `TFCD_MIN_LONG : `TFCD_MIN_SHORT;
    else if (pad_mode[1])
      pad_target = `TFCD_MIN_LONG;
    else
      pad_target = `TFCD_MIN_SHORT;
  end

  always_comb
  begin
    line_valid = 1'b0;
    line_data  = 8'h00;
    line_sof   = 1'b0;
    line_eof   = 1'b0;
    fifo_out_ready = 1'b0;
    unique case (state)
      TFCD_CTRL:
        fifo_out_ready = 1'b1;
      TFCD_PRE:
      begin
        line_valid = 1'b1;
        line_sof   = sub_cnt == 4'h0;
        line_data  = sub_cnt == `TFCD_PREAMBLE_LEN ? `TFCD_SFD_BYTE : `TFCD_PREAMBLE_BYTE;
      end
      TFCD_DATA:
      begin
        line_valid = fifo_out_valid && !over_limit;
        line_data  = fifo_out[7:0];
        line_eof   = data_last && !crc_en && byte_cnt + 16'h1 >= pad_target;
        fifo_out_ready = line_fire;
      end
      TFCD_PAD:
      begin
        line_valid = 1'b1;
        line_eof   = !crc_en && byte_cnt + 16'h1 >= pad_target;
      end
      TFCD_FCS:
      begin
        line_valid = 1'b1;
        line_data  = crc_byte;
        line_eof   = sub_cnt == 4'h3;
      end
      TFCD_FLUSH:
        fifo_out_ready = 1'b1;
      default:
        fifo_out_ready = 1'b0;
    endcase
  end

  assign crc_byte    = ~crc_val[8*sub_cnt[1:0] +: 8];
  assign crc_clear   = state == TFCD_PRE;
  assign crc_en_step = line_fire && (state == TFCD_DATA || state == TFCD_PAD);

  tfcd_crc u_crc (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .clear      (crc_clear),
    .enable     (crc_en_step),
    .data       (line_data),
    .crc        (crc_val),
    .residue_ok (crc_ok)
  );

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state      <= TFCD_IDLE;
      ctrl       <= 8'h00;
      byte_cnt   <= '0;
      sub_cnt    <= '0;
      type_field <= '0;
      tx_abort   <= 1'b0;
      giant      <= 1'b0;
      crc_error  <= 1'b0;
    end
    else
    begin
      unique case (state)
        TFCD_IDLE:
          if (tx_start)
          begin
            state    <= TFCD_CTRL;
            tx_abort <= 1'b0;
            giant    <= 1'b0;
            crc_error <= 1'b0;
          end
        TFCD_CTRL:
          if (fifo_out_valid)
          begin
            ctrl     <= fifo_out[7:0];
            sub_cnt  <= '0;
            byte_cnt <= '0;
            type_field <= '0;
            state    <= data_last ? TFCD_STAT : TFCD_PRE;
          end
        TFCD_PRE:
          if (line_fire)
          begin
            sub_cnt <= sub_cnt + 4'h1;
            if (sub_cnt == `TFCD_PREAMBLE_LEN)
              state <= TFCD_DATA;
          end
        TFCD_DATA:
          if (over_limit && fifo_out_valid)
          begin
            giant    <= 1'b1;
            tx_abort <= 1'b1;
            state    <= data_last ? TFCD_STAT : TFCD_FLUSH;
          end
          else if (line_fire)
          begin
            byte_cnt <= byte_cnt + 16'h1;
            if (byte_cnt == `TFCD_TYPE_HI_POS)
              type_field[15:8] <= line_data;
            if (byte_cnt == `TFCD_TYPE_LO_POS)
              type_field[7:0] <= line_data;
            sub_cnt <= '0;
            if (data_last)
            begin
              if (byte_cnt + 16'h1 < pad_target)
                state <= TFCD_PAD;
              else if (crc_en)
                state <= TFCD_FCS;
              else
                state <= TFCD_STAT;
            end
          end
        TFCD_PAD:
          if (line_fire)
          begin
            byte_cnt <= byte_cnt + 16'h1;
            if (byte_cnt + 16'h1 >= pad_target)
              state <= crc_en ? TFCD_FCS : TFCD_STAT;
          end
        TFCD_FCS:
          if (line_fire)
          begin
            sub_cnt <= sub_cnt + 4'h1;
            if (sub_cnt == 4'h3)
              state <= TFCD_STAT;
          end
        TFCD_FLUSH:
          if (fifo_out_valid && data_last)
            state <= TFCD_STAT;
        TFCD_STAT:
        begin
          if (sub_cnt == 4'h0 && !crc_en && !tx_abort)
            crc_error <= !crc_ok;
          sub_cnt <= '0;
          if (wr_ptr == tx_end_pointer + ADDR_W'(`TFCD_STATUS_LEN))
            state <= TFCD_DONE;
        end
        TFCD_DONE:
          state <= TFCD_IDLE;
        default:
          state <= TFCD_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Status record writer
  // ----------------------------------------------------------------------
  logic [55:0] status_vec;
  logic [2:0]  stat_idx;

  assign stat_idx   = 3'(wr_ptr - tx_end_pointer - 1'b1);
  assign status_vec = {4'h0, type_field == `TFCD_VLAN_TYPE, 3'h0, byte_cnt,
                       1'b0, giant, 6'h00, !tx_abort, 1'b0, 1'b0,
                       !crc_en && !tx_abort && !crc_ok, 4'h0,
                       byte_cnt + (crc_en && !tx_abort ? 16'h4 : 16'h0)};

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wr_ptr      <= '0;
      mem_wr_en   <= 1'b0;
      mem_wr_data <= 8'h00;
      tx_done     <= 1'b0;
    end
    else
    begin
      tx_done   <= state == TFCD_DONE;
      mem_wr_en <= 1'b0;
      if (state != TFCD_STAT)
        wr_ptr <= tx_end_pointer + 1'b1;
      else if (wr_ptr != tx_end_pointer + ADDR_W'(`TFCD_STATUS_LEN) + 1'b1)
      begin
        mem_wr_en   <= 1'b1;
        mem_wr_data <= status_vec[8*stat_idx +: 8];
        wr_ptr      <= wr_ptr + 1'b1;
      end
    end
  end

  assign mem_addr = state == TFCD_STAT || mem_wr_en ? wr_ptr - ADDR_W'(mem_wr_en) : rd_ptr;
  assign tx_busy  = state != TFCD_IDLE;
endmodule : tfcd_top
`default_nettype wire

/* File: verif/tfcd_top_assertions.sv */
// Concurrent checks on the transmit frame control decoder ports
`timescale 1ns/1ps
`default_nettype none
module tfcd_top_assertions
  import tfcd_pkg::*;
#(
  parameter int ADDR_W = 13
) (
  input wire logic              sys_clk,
  input wire logic              rst,
  input wire logic              tx_start,
  input wire logic [ADDR_W-1:0] tx_start_pointer,
  input wire logic [ADDR_W-1:0] tx_end_pointer,
  input wire logic              tx_busy,
  input wire logic              tx_done,
  input wire logic              mem_rd_en,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic              mem_wr_en,
  input wire logic [7:0]        line_data,
  input wire logic              line_valid,
  input wire logic              line_sof,
  input wire logic              line_ready
);
  // ----------------------------------------------------------------------
  // Byte and status write counters per frame
  // ----------------------------------------------------------------------
  logic [7:0] pos;
  logic [3:0] wcnt;
  logic       start_ok;
  assign start_ok = tx_start && !tx_busy;

  always_ff @(posedge sys_clk)
  begin
    if (rst || start_ok)
      pos <= 8'h00;
    else if (line_valid && line_ready && pos != 8'hff)
      pos <= pos + 8'h01;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst || start_ok)
      wcnt <= 4'h0;
    else if (mem_wr_en && wcnt != 4'hf)
      wcnt <= wcnt + 4'h1;
  end

  property p_pre_byte;
    @(posedge sys_clk) disable iff (rst) line_valid && pos < 8'h07 |-> line_data == 8'h55;
  endproperty
  a_pre_byte: assert property (p_pre_byte) else $error("preamble byte wrong");
  property p_sfd_byte;
    @(posedge sys_clk) disable iff (rst) line_valid && pos == 8'h07 |-> line_data == 8'hd5;
  endproperty
  a_sfd_byte: assert property (p_sfd_byte) else $error("delimiter byte wrong");
  property p_sof_first;
    @(posedge sys_clk) disable iff (rst) line_valid |-> line_sof == (pos == 8'h00);
  endproperty
  a_sof_first: assert property (p_sof_first) else $error("sof misplaced");
  property p_hold;
    @(posedge sys_clk) disable iff (rst)
      line_valid && !line_ready |=> line_valid && $stable(line_data) && $stable(line_sof);
  endproperty
  a_hold: assert property (p_hold) else $error("line byte dropped while stalled");
  property p_ctrl_read;
    @(posedge sys_clk) disable iff (rst)
      start_ok |-> ##[1:3] (mem_rd_en && mem_addr == tx_start_pointer);
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control byte not read");
  property p_status_addr;
    @(posedge sys_clk) disable iff (rst)
      mem_wr_en && wcnt == 4'h0 |-> mem_addr == ADDR_W'(tx_end_pointer + 1'b1);
  endproperty
  a_status_addr: assert property (p_status_addr) else $error("status address wrong");
  property p_status_len;
    @(posedge sys_clk) disable iff (rst) tx_done |-> wcnt == 4'h7;
  endproperty
  a_status_len: assert property (p_status_len) else $error("status length wrong");
  property p_done_pulse;
    @(posedge sys_clk) disable iff (rst) tx_done |=> !tx_done && !line_valid;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");
endmodule : tfcd_top_assertions

bind tfcd_top tfcd_top_assertions #(.ADDR_W(ADDR_W)) u_tfcd_chk (
  .sys_clk(sys_clk), .rst(rst), .tx_start(tx_start),
  .tx_start_pointer(tx_start_pointer), .tx_end_pointer(tx_end_pointer),
  .tx_busy(tx_busy), .tx_done(tx_done), .mem_rd_en(mem_rd_en), .mem_addr(mem_addr),
  .mem_wr_en(mem_wr_en), .line_data(line_data), .line_valid(line_valid),
  .line_sof(line_sof), .line_ready(line_ready)
);
`default_nettype wire

/* File: verif/tfcd_mem_model.sv */
// Host buffer memory model holding control byte, frame and status
`timescale 1ns/1ps
`default_nettype none
module tfcd_mem_model
  import tfcd_pkg::*;
#(
  parameter int ADDR_W = 13
) (
  input wire logic              sys_clk,
  input wire logic              mem_rd_en,
  input wire logic [ADDR_W-1:0] mem_addr,
  output logic      [7:0]       mem_rd_data,
  input wire logic              mem_wr_en,
  input wire logic [7:0]        mem_wr_data
);
  // Control byte then frame fields, loaded by the bench
  logic [7:0] m [0:(1<<ADDR_W)-1];

  initial mem_rd_data = 8'h00;

  // One-cycle read latency; idle data toggles so stale bytes show
  always @(posedge sys_clk)
  begin
    if (mem_wr_en)
      m[mem_addr] <= mem_wr_data;
    mem_rd_data <= mem_rd_en ? m[mem_addr] : ~mem_rd_data;
  end
endmodule : tfcd_mem_model
`default_nettype wire

/* File: verif/tb.sv */
// Testbench for the transmit frame control decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tfcd_pkg::*;
  localparam int AW = 13;
  localparam logic [AW-1:0] SP = 13'h0100;
  logic          sys_clk = 1'b0;
  logic          rst = 1'b1;
  logic          tx_start = 1'b0;
  logic          line_ready = 1'b1;
  logic          gca = 1'b0;
  logic          goa = 1'b0;
  logic          stall = 1'b0;
  logic          leof = 1'b0;
  logic [AW-1:0] ep = SP;
  logic [2:0]    gpc = 3'h0;
  logic [15:0]   mfl = 16'h05ee;
  logic          busy, done, abort, rd_en, wr_en, lv, sof, eof, crc_err, giant;
  logic [AW-1:0] addr;
  logic [7:0]    rdd, wrd, ld;
  int            err_count = 0;
  int            n_checks = 0;
  logic [7:0]    q[$];
  logic [7:0]    fr[$];

  always #12.5 sys_clk = ~sys_clk;

  always @(posedge sys_clk)
  begin
    line_ready <= #2 stall ? ~line_ready : 1'b1;
    if (lv === 1'b1 && line_ready === 1'b1)
    begin
      q.push_back(ld);
      leof = eof;
    end
  end

  tfcd_top #(.FIFO_DEPTH(32), .ADDR_W(AW)) DUT (
    .sys_clk(sys_clk), .rst(rst), .tx_start(tx_start), .tx_start_pointer(SP),
    .tx_end_pointer(ep), .tx_busy(busy), .tx_done(done), .tx_abort(abort),
    .global_pad_crc_code(gpc), .global_crc_append(gca), .global_oversize_allow(goa),
    .max_frame_length(mfl), .mem_rd_en(rd_en), .mem_addr(addr), .mem_rd_data(rdd),
    .mem_wr_en(wr_en), .mem_wr_data(wrd), .line_data(ld), .line_valid(lv),
    .line_sof(sof), .line_eof(eof), .line_ready(line_ready), .crc_error(crc_err),
    .giant(giant));

  tfcd_mem_model #(.ADDR_W(AW)) MEM (
    .sys_clk(sys_clk), .mem_rd_en(rd_en), .mem_addr(addr), .mem_rd_data(rdd),
    .mem_wr_en(wr_en), .mem_wr_data(wrd));

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_checks++;
    if (got !== want)
    begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, want);
    end
  endtask : chk

  function automatic logic [31:0] crc32(input int n);
    logic [31:0] c;
    c = 32'hffffffff;
    for (int i = 0; i < n; i++)
    begin
      c = c ^ {24'h000000, fr[i]};
      for (int j = 0; j < 8; j++)
        c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
    end
    return ~c;
  endfunction : crc32

  task automatic send(input logic [7:0] cb, input int n, input bit vl, input bit good);
    logic [31:0] c;
    fr.delete();
    q.delete();
    for (int i = 0; i < n; i++)
      fr.push_back(vl && i == 12 ? 8'h81 : (vl && i == 13 ? 8'h00 : 8'(i * 7 + 3)));
    if (good)
    begin
      c = crc32(n - 4);
      for (int i = 0; i < 4; i++)
        fr[n - 4 + i] = c[8 * i +: 8];
    end
    ep = SP + AW'(n);
    MEM.m[SP] = cb;
    foreach (fr[i])
      MEM.m[SP + AW'(i) + 13'h1] = fr[i];
    @(posedge sys_clk);
    #2;
    tx_start = 1'b1;
    @(posedge sys_clk);
    #2;
    tx_start = 1'b0;
    chk(busy, 1'b1);
    for (int k = 0; k < 3000 && done !== 1'b1; k++)
    begin
      @(posedge sys_clk);
      #1;
    end
    chk(done, 1'b1);
    #1;
  endtask : send

  task automatic expect_frame(input int pad, input bit crc, input bit err);
    int t;
    logic [31:0] c;
    while (fr.size() < pad)
      fr.push_back(8'h00);
    t = fr.size() + (crc ? 4 : 0);
    c = crc32(fr.size());
    chk(q.size(), 8 + t);
    for (int i = 0; i < 8 && i < q.size(); i++)
      chk(q[i], i == 7 ? 8'hd5 : 8'h55);
    for (int i = 0; i < t && i + 8 < q.size(); i++)
      chk(q[i + 8], i < fr.size() ? fr[i] : c[8 * (i - fr.size()) +: 8]);
    chk(leof, 1'b1);
    chk(crc_err, err);
    chk({MEM.m[ep + 13'h2], MEM.m[ep + 13'h1]}, t);
    chk(MEM.m[ep + 13'h3][7], 1'b1);
  endtask : expect_frame

  task automatic complete_run();
    $display("errors %0d checks %0d", err_count, n_checks);
    if (err_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  initial
  begin
    #1000000;
    err_count++;
    complete_run();
  end

  initial
  begin
    repeat (6) @(posedge sys_clk);
    #2;
    rst = 1'b0;
    send(8'hf7, 20, 1'b0, 1'b0);
    expect_frame(60, 1'b1, 1'b0);
    gpc = 3'h3;
    gca = 1'b1;
    send(8'h03, 20, 1'b0, 1'b0);
    expect_frame(0, 1'b1, 1'b0);
    send(8'h01, 20, 1'b0, 1'b1);
    expect_frame(0, 1'b0, 1'b0);
    send(8'h01, 20, 1'b0, 1'b0);
    expect_frame(0, 1'b0, 1'b1);
    gpc = 3'h0;
    gca = 1'b0;
    send(8'h0e, 20, 1'b0, 1'b0);
    expect_frame(0, 1'b0, 1'b1);
    gca = 1'b1;
    stall = 1'b1;
    for (int k = 0; k < 9; k++)
    begin
      gpc = k == 8 ? 3'h5 : 3'(k);
      send(8'h00, 20, k == 8, 1'b0);
      expect_frame(gpc[0] ? (gpc[1] || k == 8 ? 64 : 60) : 0, 1'b1, 1'b0);
    end
    stall = 1'b0;
    mfl = 16'h001e;
    gca = 1'b0;
    gpc = 3'h0;
    for (int k = 0; k < 4; k++)
    begin
      goa = k[0] ^ (k < 2);
      send(k < 2 ? {4'h0, k[0], 3'h1} : 8'h00, 40, 1'b0, 1'b0);
      chk(abort, !k[0]);
      chk(giant, !k[0]);
      chk(q.size(), k[0] ? 48 : 38);
    end
    complete_run();
  end
endmodule : tb
`default_nettype wire
